// [src/bsx_defs.svh]
// Constants of the boundary-scan test port: widths, codes and cell positions.
// ============================================================================
`ifndef BSX_DEFS_SVH
`define BSX_DEFS_SVH

// ============================================================================
// Register sizes.
`define BSX_IR_W 8
`define BSX_BSR_W 48
`define BSX_ID_W 32

// ============================================================================
// Instruction values.
`define BSX_IR_RESET 8'h81
`define BSX_IR_CAPTURE 8'h81
`define BSX_OP_EXTEST 8'h00
`define BSX_OP_IDCODE 8'h81
`define BSX_OP_SAMPLE 8'h82

// ============================================================================
// Boundary cell positions.
`define BSX_CELL_OE_HI 47
`define BSX_CELL_OE_LO 44
`define BSX_CELL_CLK_HI 43
`define BSX_CELL_CLK_LO 40
`define BSX_CELL_LE_HI 39
`define BSX_CELL_LE_LO 36
`define BSX_CELL_A_HI 35
`define BSX_CELL_A_LO 18
`define BSX_CELL_B_HI 17
`define BSX_CELL_B_LO 0
`define BSX_OE_RESET 4'hf

`endif

// [src/bsx_pin_sync.sv]
// Three-stage synchroniser for test pins, changing once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module bsx_pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pins
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);

	// ========================================================================
	// Elaboration check.
	if (W < 1) begin : g_bad_width
		$error("bsx_pin_sync needs at least one bit");
	end

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;
	logic [W-1:0] lvl_d;

	// ========================================================================
	// Each bit moves only when the two later stages agree, so a metastable
	// first stage never reaches the output directly.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
		end
	end

	// Pipeline registers; pull-up defaults reflect the idle pins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			lvl_q <= INIT;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;

endmodule
`default_nettype wire

// [src/bsx_pkg.sv]
// Types shared by the boundary-scan test port.
package bsx_pkg;

	// ========================================================================
	// Controller states, Gray coded so that neighbours in this list differ in one bit.
	typedef enum logic [3:0] {
		BSX_TLR = 4'h0,
		BSX_RTI = 4'h1,
		BSX_SEL_DR = 4'h3,
		BSX_CAP_DR = 4'h2,
		BSX_SHIFT_DR = 4'h6,
		BSX_EXIT1_DR = 4'h7,
		BSX_PAUSE_DR = 4'h5,
		BSX_EXIT2_DR = 4'h4,
		BSX_UPD_DR = 4'hc,
		BSX_SEL_IR = 4'hd,
		BSX_CAP_IR = 4'hf,
		BSX_SHIFT_IR = 4'he,
		BSX_EXIT1_IR = 4'ha,
		BSX_PAUSE_IR = 4'hb,
		BSX_EXIT2_IR = 4'h9,
		BSX_UPD_IR = 4'h8
	} bsx_tap_e;

endpackage

// [src/bsx_tap_fsm.sv]
// Test access port controller state machine, stepping on test clock rises.
`timescale 1ns/1ps
`default_nettype none
module bsx_tap_fsm import bsx_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Step strobe and mode select sampled on that step
	input wire logic step,
	input wire logic tms,
	// State
	output bsx_tap_e state
);

	bsx_tap_e state_q;
	bsx_tap_e state_d;

	// ========================================================================
	// Next state; Exit2 states may return to shift without a new capture.
	always_comb begin
		state_d = state_q;
		if (step) begin
			case (state_q)
				BSX_TLR: state_d = tms ? BSX_TLR : BSX_RTI;
				BSX_RTI: state_d = tms ? BSX_SEL_DR : BSX_RTI;
				BSX_SEL_DR: state_d = tms ? BSX_SEL_IR : BSX_CAP_DR;
				BSX_CAP_DR: state_d = tms ? BSX_EXIT1_DR : BSX_SHIFT_DR;
				BSX_SHIFT_DR: state_d = tms ? BSX_EXIT1_DR : BSX_SHIFT_DR;
				BSX_EXIT1_DR: state_d = tms ? BSX_UPD_DR : BSX_PAUSE_DR;
				BSX_PAUSE_DR: state_d = tms ? BSX_EXIT2_DR : BSX_PAUSE_DR;
				BSX_EXIT2_DR: state_d = tms ? BSX_UPD_DR : BSX_SHIFT_DR;
				BSX_UPD_DR: state_d = tms ? BSX_SEL_DR : BSX_RTI;
				BSX_SEL_IR: state_d = tms ? BSX_TLR : BSX_CAP_IR;
				BSX_CAP_IR: state_d = tms ? BSX_EXIT1_IR : BSX_SHIFT_IR;
				BSX_SHIFT_IR: state_d = tms ? BSX_EXIT1_IR : BSX_SHIFT_IR;
				BSX_EXIT1_IR: state_d = tms ? BSX_UPD_IR : BSX_PAUSE_IR;
				BSX_PAUSE_IR: state_d = tms ? BSX_EXIT2_IR : BSX_PAUSE_IR;
				BSX_EXIT2_IR: state_d = tms ? BSX_UPD_IR : BSX_SHIFT_IR;
				BSX_UPD_IR: state_d = tms ? BSX_SEL_DR : BSX_RTI;
				default: state_d = BSX_TLR;
			endcase
		end
	end

	// State register; reset puts the controller in Test-Logic-Reset.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= BSX_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	assign state = state_q;

	// ========================================================================
	// A step in Exit2-DR with mode select low always returns to Shift-DR.
	sequence s_exit_pause_dr;
		step && state_q == BSX_EXIT2_DR && !tms;
	endsequence

	AST_EXIT2_TO_SHIFT: assert property (@(posedge clk) disable iff (!rstn)
		s_exit_pause_dr |=> state_q == BSX_SHIFT_DR)
		else $error("exit2 did not return to shift-dr");

endmodule
`default_nettype wire

// [src/bsx_top.sv]
// Boundary-scan test port: pin sampling, instruction and data registers, output.
`timescale 1ns/1ps
`default_nettype none
`include "bsx_defs.svh"
module bsx_top import bsx_pkg::*; #(
	// Captured into the identification register; value is arbitrary.
	parameter logic [`BSX_ID_W-1:0] ID_VALUE = 32'h0000_0001
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Test access pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Boundary cells: sensed pin values and driven test values
	input wire logic [`BSX_BSR_W-1:0] cell_sense,
	output logic [`BSX_BSR_W-1:0] cell_drive,
	// Current instruction and mode
	output logic [`BSX_IR_W-1:0] instr,
	output logic test_mode
);

	// ========================================================================
	// Pin sampling and test clock edge detection.
	logic [2:0] pins_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_prev_q;
	logic tck_prev_d;
	logic rise;
	logic fall;
	bsx_tap_e state_q;

	bsx_pin_sync #(.W(3), .INIT(3'h7)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.pin({tck, tms, tdi}),
		.level(pins_s)
	);

	assign tck_s = pins_s[2];
	assign tms_s = pins_s[1];
	assign tdi_s = pins_s[0];

	// Edges of the clean test clock become single-cycle strobes. A test clock
	// period must span several system clocks for this to hold.
	always_comb begin
		tck_prev_d = tck_s;
		rise = tck_s & ~tck_prev_q;
		fall = ~tck_s & tck_prev_q;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tck_prev_q <= 1'b1;
		end else begin
			tck_prev_q <= tck_prev_d;
		end
	end

	bsx_tap_fsm u_fsm (
		.clk(clk),
		.rstn(rstn),
		.step(rise),
		.tms(tms_s),
		.state(state_q)
	);

	// ========================================================================
	// Instruction decode. A parity error or any unlisted opcode falls back to
	// the bypass path, which keeps the chain length predictable for a tester.
	logic [`BSX_IR_W-1:0] instr_q;
	logic parity_ok;
	logic sel_bsr;
	logic sel_id;

	always_comb begin
		parity_ok = ~(^instr_q);
		sel_bsr = parity_ok && (instr_q == `BSX_OP_EXTEST ||
			instr_q == `BSX_OP_SAMPLE);
		sel_id = parity_ok && instr_q == `BSX_OP_IDCODE;
		// Everything else goes to bypass.
	end

	// ========================================================================
	// Shift stages: instruction, boundary chain, bypass and identification.
	// Only the instruction and boundary stages carry shadow latches.
	logic [`BSX_IR_W-1:0] ir_shift_q;
	logic [`BSX_IR_W-1:0] ir_shift_d;
	logic [`BSX_BSR_W-1:0] bsr_shift_q;
	logic [`BSX_BSR_W-1:0] bsr_shift_d;
	logic [`BSX_ID_W-1:0] id_shift_q;
	logic [`BSX_ID_W-1:0] id_shift_d;
	logic byp_q;
	logic byp_d;

	// Capture and shift act on the rising test clock edge that leaves the
	// state, so the entry cycle of a shift state moves nothing.
	always_comb begin
		ir_shift_d = ir_shift_q;
		bsr_shift_d = bsr_shift_q;
		id_shift_d = id_shift_q;
		byp_d = byp_q;
		if (rise) begin
			case (state_q)
				BSX_CAP_IR: begin
					ir_shift_d = `BSX_IR_CAPTURE;
				end
				BSX_SHIFT_IR: begin
					ir_shift_d = {tdi_s, ir_shift_q[`BSX_IR_W-1:1]};
				end
				BSX_CAP_DR: begin
					// Source follows the instruction.
					if (sel_bsr) begin
						bsr_shift_d = cell_sense;
					end else if (sel_id) begin
						id_shift_d = ID_VALUE;
					end else begin
						byp_d = 1'b0;
					end
				end
				BSX_SHIFT_DR: begin
					if (sel_bsr) begin
						// Serial input enters at 47, cell 0 drives out.
						bsr_shift_d = {tdi_s, bsr_shift_q[`BSX_BSR_W-1:1]};
					end else if (sel_id) begin
						id_shift_d = {tdi_s, id_shift_q[`BSX_ID_W-1:1]};
					end else begin
						byp_d = tdi_s;
					end
				end
				// Pause and exit states leave every stage untouched.
				default: begin
				end
			endcase
		end
		if (state_q == BSX_TLR) begin
			bsr_shift_d[`BSX_CELL_OE_HI:`BSX_CELL_OE_LO] = `BSX_OE_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ir_shift_q <= `BSX_IR_RESET;
			bsr_shift_q <= {`BSX_OE_RESET, 44'h000_0000_0000};
			id_shift_q <= 32'h0000_0000;
			byp_q <= 1'b0;
		end else begin
			ir_shift_q <= ir_shift_d;
			bsr_shift_q <= bsr_shift_d;
			id_shift_q <= id_shift_d;
			byp_q <= byp_d;
		end
	end

	// ========================================================================
	// Falling edge work: serial output, instruction and boundary shadows.
	// Cells 47-44 are the output enables, 43-40 clocks, 39-36 latch enables,
	// 35-18 the A side and 17-0 the B side.
	logic [`BSX_IR_W-1:0] instr_d;
	logic [`BSX_BSR_W-1:0] shadow_q;
	logic [`BSX_BSR_W-1:0] shadow_d;
	logic tdo_q;
	logic tdo_d;
	logic tdo_oe_q;
	logic tdo_oe_d;
	logic test_mode_q;
	logic test_mode_d;
	logic dr_lsb;

	always_comb begin
		dr_lsb = sel_bsr ? bsr_shift_q[0] : (sel_id ? id_shift_q[0] : byp_q);
		instr_d = instr_q;
		shadow_d = shadow_q;
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		test_mode_d = test_mode_q;
		if (state_q == BSX_TLR) begin
			instr_d = `BSX_IR_RESET;
			shadow_d[`BSX_CELL_OE_HI:`BSX_CELL_OE_LO] = `BSX_OE_RESET;
			test_mode_d = 1'b0;
			tdo_oe_d = 1'b0;
		end else if (fall) begin
			case (state_q)
				BSX_SHIFT_IR: begin
					tdo_d = ir_shift_q[0];
					tdo_oe_d = 1'b1;
				end
				BSX_SHIFT_DR: begin
					tdo_d = dr_lsb;
					tdo_oe_d = 1'b1;
				end
				BSX_UPD_IR: begin
					instr_d = ir_shift_q;
					test_mode_d = (ir_shift_q == `BSX_OP_EXTEST);
					tdo_oe_d = 1'b0;
				end
				BSX_UPD_DR: begin
					if (sel_bsr) begin
						shadow_d = bsr_shift_q;
					end
					tdo_oe_d = 1'b0;
				end
				default: begin
					tdo_oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			instr_q <= `BSX_IR_RESET;
			shadow_q <= {`BSX_OE_RESET, 44'h000_0000_0000};
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
			test_mode_q <= 1'b0;
		end else begin
			instr_q <= instr_d;
			shadow_q <= shadow_d;
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
			test_mode_q <= test_mode_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;
	assign cell_drive = shadow_q;
	assign instr = instr_q;
	assign test_mode = test_mode_q;

	// ========================================================================
	// Checks.
	sequence s_fall_in(bsx_tap_e st);
		fall && state_q == st;
	endsequence

	sequence s_rise_in(bsx_tap_e st);
		rise && state_q == st;
	endsequence

	AST_IR_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
		s_rise_in(BSX_CAP_IR) |=> ir_shift_q == 8'h81)
		else $error("capture-ir did not load the fixed pattern");

	AST_IR_SHIFT: assert property (@(posedge clk) disable iff (!rstn)
		s_rise_in(BSX_SHIFT_IR) |=>
		ir_shift_q == {$past(tdi_s), $past(ir_shift_q[7:1])})
		else $error("instruction shift moved wrong data");

	AST_TDO_ON: assert property (@(posedge clk) disable iff (!rstn)
		s_fall_in(BSX_SHIFT_IR) |=> tdo_oe_q && tdo_q == $past(ir_shift_q[0]))
		else $error("serial output not driving instruction lsb");

	AST_TDO_OFF: assert property (@(posedge clk) disable iff (!rstn)
		(s_fall_in(BSX_EXIT1_IR) or s_fall_in(BSX_EXIT1_DR)) |=> !tdo_oe_q)
		else $error("serial output still driven after exit1");

	AST_PAUSE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		state_q == BSX_PAUSE_IR || state_q == BSX_PAUSE_DR |=>
		$stable(ir_shift_q) && $stable(bsr_shift_q))
		else $error("shift contents changed during pause");

	AST_IR_UPDATE: assert property (@(posedge clk) disable iff (!rstn)
		s_fall_in(BSX_UPD_IR) |=> instr_q == $past(ir_shift_q))
		else $error("update-ir did not load the instruction");

	AST_BSR_UPDATE: assert property (@(posedge clk) disable iff (!rstn)
		s_fall_in(BSX_UPD_DR) ##0 sel_bsr |=> cell_drive == $past(bsr_shift_q))
		else $error("update-dr did not load the boundary shadow");

	AST_IR_RESET: assert property (@(posedge clk) disable iff (!rstn)
		state_q == BSX_TLR |=> instr_q == 8'h81 && !test_mode_q)
		else $error("instruction not forced in test-logic-reset");

	AST_OE_CELLS: assert property (@(posedge clk) disable iff (!rstn)
		state_q == BSX_TLR |=> cell_drive[47:44] == 4'hf &&
		bsr_shift_q[47:44] == 4'hf)
		else $error("enable cells not set in test-logic-reset");

	AST_BYPASS_DEFAULT: assert property (@(posedge clk) disable iff (!rstn)
		s_rise_in(BSX_CAP_DR) ##0 !sel_bsr ##0 !sel_id |=> !byp_q)
		else $error("unlisted opcode did not capture through bypass");

endmodule
`default_nettype wire

// [verif/bsx_scan_host.sv]
// Behavioural boundary-scan controller that clocks the test port pins.
`timescale 1ns/1ps
`default_nettype none
module bsx_scan_host #(
	parameter int HALF = 8
) (
	// Clock
	input wire logic clk,
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// ========================================================================
	// Pin sample taken late in each low phase, and its announcement.
	logic [1:0] seen;
	event sampled;

	// Pins idle with the pulled-up levels and the test clock parked low.
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		seen = 2'h0;
	end

	// One test clock period. The half period is stretched beyond the bench
	// link rate because the pin synchroniser needs about four clocks to
	// answer; pins move early in the low phase and stay put through the high
	// phase, so the device sees them settled at its rise.
	task automatic step(input logic m, input logic d);
		@(negedge clk);
		tms = m;
		tdi = d;
		repeat (HALF) @(negedge clk);
		seen = {tdo_oe, tdo};
		-> sampled;
		tck = 1'h1;
		repeat (HALF) @(negedge clk);
		tck = 1'h0;
		tdi = 1'h1;
	endtask
endmodule
`default_nettype wire

// [verif/bsx_top_tb.sv]
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
`include "bsx_defs.svh"
module bsx_top_tb;
	// ========================================================================
	// Clock, reset, pins and bench state.
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [`BSX_BSR_W-1:0] cell_sense = 48'h0;
	wire logic tck, tms, tdi, tdo, tdo_oe, test_mode;
	wire logic [`BSX_BSR_W-1:0] cell_drive;
	wire logic [`BSX_IR_W-1:0] instr;
	int mismatches = 0;
	int n_compared = 0;
	logic [31:0] rng = 32'd53074;
	logic [1:0] exp_q[$];
	logic [1:0] note;
	bit armed = 1'b0;
	logic [47:0] din, hold;
	logic [7:0] bp_ops[2] = '{8'h03, 8'h83};

	always #20 clk = ~clk;

	bsx_top dut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .cell_sense(cell_sense),
		.cell_drive(cell_drive), .instr(instr), .test_mode(test_mode));
	bsx_scan_host u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe));

	// ========================================================================
	// Helpers: random source, compares and the closing report.
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic cmp_bit(input string what, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", what, e, s);
		end
	endtask

	task automatic cmp_reg(input string what, input logic [47:0] e,
		input logic [47:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ========================================================================
	// Serial monitor: each armed pin sample is matched to the oldest note.
	always @(u_host.sampled) begin
		if (armed) begin
			if (exp_q.size() == 0) begin
				cmp_bit("note_queue", 1'h1, 1'h0);
			end else begin
				note = exp_q.pop_front();
				cmp_bit("tdo_oe", note[1], u_host.seen[1]);
				if (note[1]) cmp_bit("tdo", note[0], u_host.seen[0]);
			end
		end
	end

	// One test clock step; an armed step notes {output enable, data}.
	task automatic go(input logic m, input logic d, input bit a,
		input logic [1:0] e);
		armed = a;
		if (a) exp_q.push_back(e);
		u_host.step(m, d);
	endtask

	// Scan from Run-Test/Idle back to it. The pause option parks the scan
	// halfway, which is where a lost bit or a leaky shadow would show.
	task automatic scan(input bit ir, input int n, input logic [47:0] d,
		input logic [47:0] e, input bit pause);
		int i;
		hold = ir ? {40'h0, instr} : cell_drive;
		go(1'h1, 1'h1, 1'b0, 2'h0);
		if (ir) go(1'h1, 1'h1, 1'b0, 2'h0);
		go(1'h0, 1'h1, 1'b0, 2'h0);
		go(1'h0, 1'h1, 1'b0, 2'h0);
		for (i = 0; i < n; i++) begin
			go(i == n - 1 || (pause && i == n / 2 - 1), d[i], 1'b1,
				{1'h1, e[i]});
			if (pause && i == n / 2 - 1) begin
				go(1'h0, 1'h1, 1'b1, 2'h0);
				go(1'h0, 1'h1, 1'b1, 2'h0);
				cmp_reg("shadow", hold, ir ? {40'h0, instr} : cell_drive);
				go(1'h1, 1'h1, 1'b1, 2'h0);
				go(1'h0, 1'h1, 1'b1, 2'h0);
			end
		end
		go(1'h1, 1'h1, 1'b1, 2'h0);
		go(1'h0, 1'h1, 1'b1, 2'h0);
	endtask

	// ========================================================================
	// Main sequence.
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1'h1;
		repeat (6) @(negedge clk);
		cmp_reg("instr", `BSX_IR_RESET, {40'h0, instr});
		cmp_reg("oe_cells", `BSX_OE_RESET, {44'h0, cell_drive[47:44]});
		cmp_reg("tdo_oe", 48'h0, {47'h0, tdo_oe});
		$display("test reset done");
		// The reset instruction selects the identification path; read it.
		go(1'h0, 1'h1, 1'b0, 2'h0);
		din[31:0] = xs();
		din[47:32] = 16'h0;
		scan(1'b0, 32, din, {16'h0, 32'h0000_0001}, 1'b0);
		cmp_reg("instr", `BSX_IR_RESET, {40'h0, instr});
		$display("test identification done");
		// Load the sampling instruction through a paused instruction scan.
		scan(1'b1, 8, `BSX_OP_SAMPLE, `BSX_IR_CAPTURE, 1'b1);
		cmp_reg("instr", `BSX_OP_SAMPLE, {40'h0, instr});
		$display("test instruction scan done");
		// Capture random pin values while preloading a random pattern.
		din[31:0] = xs();
		din[47:32] = 16'(xs());
		cell_sense[31:0] = xs();
		cell_sense[47:32] = 16'(xs());
		scan(1'b0, 48, din, cell_sense, 1'b1);
		cmp_reg("cell_drive", din, cell_drive);
		cmp_reg("test_mode", 48'h0, {47'h0, test_mode});
		$display("test boundary scan done");
		// Test mode follows the external-test code; shadows are kept.
		scan(1'b1, 8, `BSX_OP_EXTEST, `BSX_IR_CAPTURE, 1'b0);
		cmp_reg("test_mode", 48'h1, {47'h0, test_mode});
		cmp_reg("cell_drive", din, cell_drive);
		// Five rises with mode select high land in Test-Logic-Reset.
		repeat (5) go(1'h1, 1'h1, 1'b0, 2'h0);
		cmp_reg("instr", `BSX_IR_RESET, {40'h0, instr});
		cmp_reg("oe_cells", `BSX_OE_RESET, {44'h0, cell_drive[47:44]});
		cmp_reg("test_mode", 48'h0, {47'h0, test_mode});
		$display("test logic reset done");
		// A family bypass code and a parity-broken code give a 1-bit path.
		go(1'h0, 1'h1, 1'b0, 2'h0);
		foreach (bp_ops[k]) begin
			scan(1'b1, 8, {40'h0, bp_ops[k]}, `BSX_IR_CAPTURE, 1'b0);
			cmp_reg("instr", {40'h0, bp_ops[k]}, {40'h0, instr});
			din[7:0] = 8'(xs());
			scan(1'b0, 8, din, {40'h0, din[6:0], 1'h0}, 1'b0);
		end
		$display("test bypass done");
		end_of_test();
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
